/* omv_regs.svh */
`ifndef OMV_REGS_SVH
`define OMV_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OMV_OFF_PWR_ONE 7'h01
`define OMV_OFF_PWR_THREE 7'h03
`define OMV_OFF_ADD_CTRL 7'h07
`define OMV_OFF_BYP_ATTEN 7'h28
`define OMV_OFF_SPK_MIX 7'h32
`define OMV_OFF_SPK_VOL 7'h36
`define OMV_OFF_MONO_MIX 7'h38
`define OMV_OFF_ZC_STATUS 7'h3A

// ----------------------------------------
// writable bits and reset values
// ----------------------------------------
`define OMV_MASK_PWR_ONE 9'h10C
`define OMV_MASK_PWR_THREE 9'h0EC
`define OMV_MASK_ADD_CTRL 9'h001
`define OMV_MASK_BYP_ATTEN 9'h006
`define OMV_MASK_SPK_MIX 9'h023
`define OMV_MASK_SPK_VOL 9'h0FF
`define OMV_MASK_MONO_MIX 9'h007
`define OMV_RST_SPK_MIX 9'h001
`define OMV_RST_SPK_VOL 9'h039
`define OMV_RST_ZERO 9'h000

// ----------------------------------------
// field positions
// ----------------------------------------
`define OMV_BIT_TIEOFF_BUFFER_ON 2
`define OMV_BIT_AMP_BIAS_ON 3
`define OMV_BIT_HIGH_MID_DRIVER_ON 8
`define OMV_BIT_SPEAKER_MIXER_ON 2
`define OMV_BIT_MONO_MIXER_ON 3
`define OMV_BIT_SPEAKER_POS_ON 5
`define OMV_BIT_SPEAKER_NEG_ON 6
`define OMV_BIT_MONO_DRIVER_ON 7
`define OMV_BIT_SLOW_TICK_ENABLE 0
`define OMV_BIT_SPK_BYPASS_ATTEN 1
`define OMV_BIT_MONO_BYPASS_ATTEN 2
`define OMV_BIT_DAC_TO_SPEAKER_SEL 0
`define OMV_BIT_BYPASS_TO_SPEAKER_SEL 1
`define OMV_BIT_SECOND_MIC_TO_SPEAKER_SEL 5
`define OMV_BIT_DAC_TO_MONO_SEL 0
`define OMV_BIT_BYPASS_TO_MONO_SEL 1
`define OMV_BIT_SECOND_MIC_TO_MONO_SEL 2
`define OMV_BIT_SPEAKER_GAIN_ZERO_CROSS 7
`define OMV_BIT_SPEAKER_SILENCE 6
`define OMV_BIT_ZC_PENDING 6

// ----------------------------------------
// timing: timeout in master clock periods
// ----------------------------------------
`define OMV_ZC_TIMEOUT_EXP 21
`define OMV_ZC_TIMEOUT_CYCLES (32'd1 << `OMV_ZC_TIMEOUT_EXP)

`endif

/* omv_pkg.sv */
package omv_pkg;

  typedef enum logic [1:0] {
    OMV_ZC_IDLE = 2'b01,
    OMV_ZC_WAIT = 2'b10
  } omv_zc_state_e;

  typedef struct packed {
    logic bypass_atten;
    logic second_mic;
    logic bypass;
    logic dac;
  } omv_mix_s;

  typedef struct packed {
    logic tieoff_buffer_on;
    logic amp_bias_on;
    logic high_mid_driver_on;
    logic speaker_mixer_on;
    logic mono_mixer_on;
    logic speaker_pos_on;
    logic speaker_neg_on;
    logic mono_driver_on;
  } omv_pwr_s;

  typedef logic [8:0] omv_word_t;

endpackage

/* omv_slow_tick.sv */
`timescale 1ns/1ps
`include "omv_regs.svh"

module omv_slow_tick import omv_pkg::*; #(
  parameter int unsigned CYCLES = `OMV_ZC_TIMEOUT_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic restart_in,
  output logic tick_out
);

  logic [22:0] count_reg;
  logic [22:0] count_next;
  logic wrap;

  assign wrap = (count_reg == 23'(CYCLES - 1));
  // restart wins over counting so a fresh gain gets a full period
  assign count_next = (restart_in || !enable_in || wrap) ? 23'h000000 : count_reg + 23'h000001;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= 23'h000000;
      tick_out <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_out <= enable_in && !restart_in && wrap;
    end
  end

  property p_restart_clears;
    @(posedge clk_in) disable iff (!resetn_in)
    restart_in |=> (count_reg == 23'h000000) && !tick_out;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear count");

  property p_period;
    @(posedge clk_in) disable iff (!resetn_in)
    (enable_in && !restart_in && count_reg == 23'(CYCLES - 1)) |=> tick_out && (count_reg == 23'h000000);
  endproperty
  a_period: assert property (p_period) else $error("tick missing at end of period");

endmodule // omv_slow_tick

/* omv_top.sv */
`timescale 1ns/1ps
`include "omv_regs.svh"

// How it works
// - speaker mixer sums dac, bypass, second mic; dac selected after reset
// - speaker bypass attenuation bit: clear 0dB, set -10dB
// - six-bit speaker gain, 1dB steps, reset code gives 0dB
// - zero-cross bit set delays gain change to a crossing, else immediate
// - silence bit mutes speaker, drivers stay on at mid level
// - negative speaker output is the inverted positive output from the first clock after reset
// - pending zero-cross change applies after timeout when slow tick enabled
// - timeout is 2^21 master clock periods
// - one enable bit gates the slow tick for debounce and timeout
// - mono mixer drives any combination of dac, bypass, second mic
// - mono bypass attenuation bit: clear none, set -10dB
// - every output and mixer has its own enable, all off after reset
// - power one holds tie-off, bias and mid-level driver enables
// - power three holds mixer and driver enables, all default off

module omv_top import omv_pkg::*; #(
  parameter int unsigned ZC_TIMEOUT_CYCLES = `OMV_ZC_TIMEOUT_CYCLES
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [6:0] ADDR_IN,
  input wire logic [8:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic ZERO_CROSS_IN,
  input wire logic INPUT_ZC_PENDING_IN,
  output logic [8:0] RDATA_OUT,
  output omv_mix_s SPK_MIX_OUT,
  output omv_mix_s MONO_MIX_OUT,
  output omv_pwr_s POWER_OUT,
  output logic [5:0] SPEAKER_GAIN_CODE_OUT,
  output logic SPEAKER_SILENCE_OUT,
  output logic SPEAKER_NEG_INVERT_OUT,
  output logic SLOW_TICK_OUT,
  output logic ZC_TIMEOUT_OUT
);

  localparam int NREG = 7;
  localparam int I_PWR_ONE = 0;
  localparam int I_PWR_THREE = 1;
  localparam int I_ADD = 2;
  localparam int I_ATT = 3;
  localparam int I_SPK_MIX = 4;
  localparam int I_SPK_VOL = 5;
  localparam int I_MONO_MIX = 6;

  // ----------------------------------------
  // register table lookups
  // ----------------------------------------
  function automatic logic [6:0] reg_off(input int idx);
    case (idx)
      I_PWR_ONE: reg_off = `OMV_OFF_PWR_ONE;
      I_PWR_THREE: reg_off = `OMV_OFF_PWR_THREE;
      I_ADD: reg_off = `OMV_OFF_ADD_CTRL;
      I_ATT: reg_off = `OMV_OFF_BYP_ATTEN;
      I_SPK_MIX: reg_off = `OMV_OFF_SPK_MIX;
      I_SPK_VOL: reg_off = `OMV_OFF_SPK_VOL;
      default: reg_off = `OMV_OFF_MONO_MIX;
    endcase
  endfunction

  function automatic omv_word_t reg_mask(input int idx);
    case (idx)
      I_PWR_ONE: reg_mask = `OMV_MASK_PWR_ONE;
      I_PWR_THREE: reg_mask = `OMV_MASK_PWR_THREE;
      I_ADD: reg_mask = `OMV_MASK_ADD_CTRL;
      I_ATT: reg_mask = `OMV_MASK_BYP_ATTEN;
      I_SPK_MIX: reg_mask = `OMV_MASK_SPK_MIX;
      I_SPK_VOL: reg_mask = `OMV_MASK_SPK_VOL;
      default: reg_mask = `OMV_MASK_MONO_MIX;
    endcase
  endfunction

  function automatic omv_word_t reg_rst(input int idx);
    case (idx)
      I_SPK_MIX: reg_rst = `OMV_RST_SPK_MIX;
      I_SPK_VOL: reg_rst = `OMV_RST_SPK_VOL;
      default: reg_rst = `OMV_RST_ZERO;
    endcase
  endfunction

  function automatic logic hit(input logic [6:0] addr, input logic [6:0] off);
    hit = (addr == off);
  endfunction

  // ----------------------------------------
  // register file
  // ----------------------------------------
  omv_word_t regs_reg [NREG];
  logic [NREG-1:0] wr_sel;
  logic [NREG-1:0] rd_sel;
  omv_word_t rd_terms [NREG];

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign wr_sel[gi] = WR_IN && hit(ADDR_IN, reg_off(gi));
      assign rd_sel[gi] = hit(ADDR_IN, reg_off(gi));
      assign rd_terms[gi] = rd_sel[gi] ? regs_reg[gi] : 9'h000;
      // reserved bits never store, so they read as zero
      always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          regs_reg[gi] <= reg_rst(gi);
        end else if (wr_sel[gi]) begin
          regs_reg[gi] <= WDATA_IN & reg_mask(gi);
        end
      end
    end
  endgenerate

  omv_word_t pwr_one;
  omv_word_t pwr_three;
  omv_word_t add_ctrl;
  omv_word_t byp_atten;
  omv_word_t spk_mix;
  omv_word_t spk_vol;
  omv_word_t mono_mix;

  assign pwr_one = regs_reg[I_PWR_ONE];
  assign pwr_three = regs_reg[I_PWR_THREE];
  assign add_ctrl = regs_reg[I_ADD];
  assign byp_atten = regs_reg[I_ATT];
  assign spk_mix = regs_reg[I_SPK_MIX];
  assign spk_vol = regs_reg[I_SPK_VOL];
  assign mono_mix = regs_reg[I_MONO_MIX];

  // ----------------------------------------
  // mixer routing and power enables
  // ----------------------------------------
  assign SPK_MIX_OUT.dac = spk_mix[`OMV_BIT_DAC_TO_SPEAKER_SEL];
  assign SPK_MIX_OUT.bypass = spk_mix[`OMV_BIT_BYPASS_TO_SPEAKER_SEL];
  assign SPK_MIX_OUT.second_mic = spk_mix[`OMV_BIT_SECOND_MIC_TO_SPEAKER_SEL];
  assign SPK_MIX_OUT.bypass_atten = byp_atten[`OMV_BIT_SPK_BYPASS_ATTEN];
  assign MONO_MIX_OUT.dac = mono_mix[`OMV_BIT_DAC_TO_MONO_SEL];
  assign MONO_MIX_OUT.bypass = mono_mix[`OMV_BIT_BYPASS_TO_MONO_SEL];
  assign MONO_MIX_OUT.second_mic = mono_mix[`OMV_BIT_SECOND_MIC_TO_MONO_SEL];
  assign MONO_MIX_OUT.bypass_atten = byp_atten[`OMV_BIT_MONO_BYPASS_ATTEN];

  // enables pass straight through; pop avoidance is left to software
  assign POWER_OUT.tieoff_buffer_on = pwr_one[`OMV_BIT_TIEOFF_BUFFER_ON];
  assign POWER_OUT.amp_bias_on = pwr_one[`OMV_BIT_AMP_BIAS_ON];
  assign POWER_OUT.high_mid_driver_on = pwr_one[`OMV_BIT_HIGH_MID_DRIVER_ON];
  assign POWER_OUT.speaker_mixer_on = pwr_three[`OMV_BIT_SPEAKER_MIXER_ON];
  assign POWER_OUT.mono_mixer_on = pwr_three[`OMV_BIT_MONO_MIXER_ON];
  assign POWER_OUT.speaker_pos_on = pwr_three[`OMV_BIT_SPEAKER_POS_ON];
  assign POWER_OUT.speaker_neg_on = pwr_three[`OMV_BIT_SPEAKER_NEG_ON];
  assign POWER_OUT.mono_driver_on = pwr_three[`OMV_BIT_MONO_DRIVER_ON];

  // mute only silences the signal; drivers keep their enables
  assign SPEAKER_SILENCE_OUT = spk_vol[`OMV_BIT_SPEAKER_SILENCE];

  // ----------------------------------------
  // speaker gain and zero-cross update
  // ----------------------------------------
  omv_zc_state_e zc_state_reg;
  omv_zc_state_e zc_state_next;
  logic [5:0] gain_applied_reg;
  logic [5:0] gain_applied_next;
  logic vol_wr;
  logic wr_zc;
  logic zc_on;
  logic slow_en;
  logic apply_pending;
  logic timeout_restart;
  logic timeout_en;
  logic neg_invert_reg;

  assign vol_wr = wr_sel[I_SPK_VOL];
  assign wr_zc = WDATA_IN[`OMV_BIT_SPEAKER_GAIN_ZERO_CROSS];
  assign zc_on = spk_vol[`OMV_BIT_SPEAKER_GAIN_ZERO_CROSS];
  assign slow_en = add_ctrl[`OMV_BIT_SLOW_TICK_ENABLE];
  // turning zero-cross off releases a held gain at once
  assign apply_pending = (zc_state_reg == OMV_ZC_WAIT) && (ZERO_CROSS_IN || ZC_TIMEOUT_OUT || !zc_on);
  assign timeout_en = slow_en && ((zc_state_reg == OMV_ZC_WAIT) || INPUT_ZC_PENDING_IN);
  assign timeout_restart = vol_wr || apply_pending;

  always_comb begin
    zc_state_next = zc_state_reg;
    gain_applied_next = gain_applied_reg;
    case (zc_state_reg)
      OMV_ZC_IDLE: begin
        zc_state_next = OMV_ZC_IDLE;
      end
      OMV_ZC_WAIT: begin
        if (apply_pending) begin
          gain_applied_next = spk_vol[5:0];
          zc_state_next = OMV_ZC_IDLE;
        end
      end
      default: begin
        zc_state_next = OMV_ZC_IDLE;
      end
    endcase
    // a zero-cross write landing with an apply still leaves the new code pending
    if (vol_wr) begin
      if (wr_zc) begin
        zc_state_next = OMV_ZC_WAIT;
      end else begin
        gain_applied_next = WDATA_IN[5:0];
        zc_state_next = OMV_ZC_IDLE;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      zc_state_reg <= OMV_ZC_IDLE;
      gain_applied_reg <= 6'(`OMV_RST_SPK_VOL);
      neg_invert_reg <= 1'b0;
    end else begin
      zc_state_reg <= zc_state_next;
      gain_applied_reg <= gain_applied_next;
      neg_invert_reg <= 1'b1;
    end
  end

  assign SPEAKER_GAIN_CODE_OUT = gain_applied_reg;
  assign SPEAKER_NEG_INVERT_OUT = neg_invert_reg;

  // ----------------------------------------
  // slow ticks
  // ----------------------------------------
  // separate dividers so gain writes never disturb the debounce rate
  omv_slow_tick #(.CYCLES(ZC_TIMEOUT_CYCLES)) u_debounce_tick (
    .clk_in(CORE_CLK_IN),
    .resetn_in(RESETN_IN),
    .enable_in(slow_en),
    .restart_in(1'b0),
    .tick_out(SLOW_TICK_OUT)
  );

  omv_slow_tick #(.CYCLES(ZC_TIMEOUT_CYCLES)) u_timeout_tick (
    .clk_in(CORE_CLK_IN),
    .resetn_in(RESETN_IN),
    .enable_in(timeout_en),
    .restart_in(timeout_restart),
    .tick_out(ZC_TIMEOUT_OUT)
  );

  // ----------------------------------------
  // read port
  // ----------------------------------------
  omv_word_t status_word;
  omv_word_t rd_mux;

  assign status_word = {2'b00, (zc_state_reg == OMV_ZC_WAIT), gain_applied_reg};

  always_comb begin
    rd_mux = hit(ADDR_IN, `OMV_OFF_ZC_STATUS) ? status_word : 9'h000;
    for (int k = 0; k < NREG; k++) begin
      rd_mux = rd_mux | rd_terms[k];
    end
  end

  // data stands for exactly the cycle after the strobe
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      RDATA_OUT <= 9'h000;
    end else begin
      RDATA_OUT <= RD_IN ? rd_mux : 9'h000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_write_direct;
    vol_wr && !wr_zc;
  endsequence

  sequence s_wait_cross;
    (zc_state_reg == OMV_ZC_WAIT) && zc_on && ZERO_CROSS_IN && !vol_wr;
  endsequence

  property p_direct_gain;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    s_write_direct |=> (SPEAKER_GAIN_CODE_OUT == $past(WDATA_IN[5:0])) && (zc_state_reg == OMV_ZC_IDLE);
  endproperty
  a_direct_gain: assert property (p_direct_gain) else $error("gain not applied at once");

  property p_hold_gain;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ((zc_state_reg == OMV_ZC_WAIT) && zc_on && !ZERO_CROSS_IN && !ZC_TIMEOUT_OUT && !vol_wr)
      |=> $stable(SPEAKER_GAIN_CODE_OUT) && (zc_state_reg == OMV_ZC_WAIT);
  endproperty
  a_hold_gain: assert property (p_hold_gain) else $error("gain changed without a crossing");

  property p_cross_gain;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    s_wait_cross |=> (SPEAKER_GAIN_CODE_OUT == $past(spk_vol[5:0])) && (zc_state_reg == OMV_ZC_IDLE);
  endproperty
  a_cross_gain: assert property (p_cross_gain) else $error("gain missed the crossing");

  property p_timeout_apply;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ((zc_state_reg == OMV_ZC_WAIT) && ZC_TIMEOUT_OUT && !vol_wr) |=> (zc_state_reg == OMV_ZC_IDLE);
  endproperty
  a_timeout_apply: assert property (p_timeout_apply) else $error("timeout did not apply gain");

  property p_slow_gate;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    !slow_en [*2] |-> !SLOW_TICK_OUT && !ZC_TIMEOUT_OUT;
  endproperty
  a_slow_gate: assert property (p_slow_gate) else $error("slow tick while disabled");

  property p_mute_keeps_drivers;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    (vol_wr && WDATA_IN[`OMV_BIT_SPEAKER_SILENCE] && !wr_sel[I_PWR_THREE])
      |=> SPEAKER_SILENCE_OUT && $stable(POWER_OUT.speaker_pos_on) && $stable(POWER_OUT.speaker_neg_on);
  endproperty
  a_mute_keeps_drivers: assert property (p_mute_keeps_drivers) else $error("mute disturbed drivers");

  property p_neg_invert;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    $past(RESETN_IN) |-> SPEAKER_NEG_INVERT_OUT;
  endproperty
  a_neg_invert: assert property (p_neg_invert) else $error("negative output not inverted");

  property p_power_three;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    wr_sel[I_PWR_THREE] |=> (POWER_OUT.speaker_mixer_on == $past(WDATA_IN[2]))
      && (POWER_OUT.mono_driver_on == $past(WDATA_IN[7])) && (POWER_OUT.speaker_neg_on == $past(WDATA_IN[6]));
  endproperty
  a_power_three: assert property (p_power_three) else $error("power three enables wrong");

  property p_mixers;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    wr_sel[I_SPK_MIX] |=> (SPK_MIX_OUT.second_mic == $past(WDATA_IN[5])) && (SPK_MIX_OUT.dac == $past(WDATA_IN[0]));
  endproperty
  a_mixers: assert property (p_mixers) else $error("speaker mixer select wrong");

  property p_restart_timeout;
    @(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ((zc_state_reg == OMV_ZC_WAIT) && vol_wr) |=> !ZC_TIMEOUT_OUT;
  endproperty
  a_restart_timeout: assert property (p_restart_timeout) else $error("timeout not restarted");

endmodule // omv_top

/* tb.sv */
`timescale 1ns/1ps
`include "omv_regs.svh"

module tb import omv_pkg::*;;

  // ----------------------------------------
  // signals and design under test
  // ----------------------------------------
  localparam int unsigned ZC = 16;
  localparam int LIMIT = 5000;

  logic clk;
  logic resetn;
  logic [6:0] addr;
  logic [8:0] wdata;
  logic wr;
  logic rd;
  logic zc;
  logic in_pend;
  logic [8:0] rdata;
  omv_mix_s spk_mix;
  omv_mix_s mono_mix;
  omv_pwr_s pwr;
  logic [5:0] gain;
  logic silence;
  logic neg_inv;
  logic slow_tick;
  logic zc_to;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int m;

  omv_top #(.ZC_TIMEOUT_CYCLES(ZC)) omv_top_inst (
    .CORE_CLK_IN(clk),
    .RESETN_IN(resetn),
    .ADDR_IN(addr),
    .WDATA_IN(wdata),
    .WR_IN(wr),
    .RD_IN(rd),
    .ZERO_CROSS_IN(zc),
    .INPUT_ZC_PENDING_IN(in_pend),
    .RDATA_OUT(rdata),
    .SPK_MIX_OUT(spk_mix),
    .MONO_MIX_OUT(mono_mix),
    .POWER_OUT(pwr),
    .SPEAKER_GAIN_CODE_OUT(gain),
    .SPEAKER_SILENCE_OUT(silence),
    .SPEAKER_NEG_INVERT_OUT(neg_inv),
    .SLOW_TICK_OUT(slow_tick),
    .ZC_TIMEOUT_OUT(zc_to)
  );

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_check(input logic [6:0] a, input logic [8:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check({7'h00, rdata}, {7'h00, e});
  endtask

  // set one field, look at every power and mixer output, clear it again
  task automatic field(input logic [6:0] a, input logic [8:0] d, input logic [15:0] e);
    wr_reg(a, d);
    @(negedge clk);
    check({pwr, spk_mix, mono_mix}, e);
    wr_reg(a, 9'h000);
  endtask

  // counts sampled cycles until the chosen pulse, max when it never comes
  task automatic wait_tick(input bit sel, input int max, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (cnt < max && (sel ? slow_tick : zc_to) !== 1'b1);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    addr = 7'h00;
    wdata = 9'h000;
    wr = 1'b0;
    rd = 1'b0;
    zc = 1'b0;
    in_pend = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({pwr, spk_mix, mono_mix}, 16'h0010);
    check({10'h000, gain}, 16'h0039);
    @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check({15'h0000, neg_inv}, 16'h0000);
    @(negedge clk);
    check({15'h0000, neg_inv}, 16'h0001);
    rd_check(`OMV_OFF_PWR_ONE, 9'h000);
    rd_check(`OMV_OFF_PWR_THREE, 9'h000);
    rd_check(`OMV_OFF_ADD_CTRL, 9'h000);
    rd_check(`OMV_OFF_BYP_ATTEN, 9'h000);
    rd_check(`OMV_OFF_SPK_MIX, 9'h001);
    rd_check(`OMV_OFF_SPK_VOL, 9'h039);
    rd_check(`OMV_OFF_MONO_MIX, 9'h000);
    // reserved bits must not stick; unmapped place stays silent
    wr_reg(`OMV_OFF_PWR_ONE, 9'h1FF);
    wr_reg(`OMV_OFF_PWR_THREE, 9'h1FF);
    wr_reg(`OMV_OFF_BYP_ATTEN, 9'h1FF);
    wr_reg(`OMV_OFF_SPK_MIX, 9'h1FF);
    wr_reg(`OMV_OFF_MONO_MIX, 9'h1FF);
    wr_reg(7'h05, 9'h1FF);
    rd_check(`OMV_OFF_PWR_ONE, 9'h10C);
    rd_check(`OMV_OFF_PWR_THREE, 9'h0EC);
    rd_check(`OMV_OFF_BYP_ATTEN, 9'h006);
    rd_check(`OMV_OFF_SPK_MIX, 9'h023);
    rd_check(`OMV_OFF_MONO_MIX, 9'h007);
    rd_check(7'h05, 9'h000);
    check({pwr, spk_mix, mono_mix}, 16'hFFFF);
    wr_reg(`OMV_OFF_PWR_ONE, 9'h000);
    wr_reg(`OMV_OFF_PWR_THREE, 9'h000);
    wr_reg(`OMV_OFF_BYP_ATTEN, 9'h000);
    wr_reg(`OMV_OFF_SPK_MIX, 9'h000);
    wr_reg(`OMV_OFF_MONO_MIX, 9'h000);
    // one enable or select at a time catches swapped positions
    field(`OMV_OFF_PWR_ONE, 9'h004, 16'h8000);
    field(`OMV_OFF_PWR_ONE, 9'h008, 16'h4000);
    field(`OMV_OFF_PWR_ONE, 9'h100, 16'h2000);
    // the tie-off buffer is switched on before the outputs come up, against pops
    wr_reg(`OMV_OFF_PWR_ONE, 9'h004);
    field(`OMV_OFF_PWR_THREE, 9'h004, 16'h9000);
    field(`OMV_OFF_PWR_THREE, 9'h008, 16'h8800);
    field(`OMV_OFF_PWR_THREE, 9'h020, 16'h8400);
    field(`OMV_OFF_PWR_THREE, 9'h040, 16'h8200);
    field(`OMV_OFF_PWR_THREE, 9'h080, 16'h8100);
    wr_reg(`OMV_OFF_PWR_ONE, 9'h000);
    field(`OMV_OFF_BYP_ATTEN, 9'h002, 16'h0080);
    field(`OMV_OFF_BYP_ATTEN, 9'h004, 16'h0008);
    field(`OMV_OFF_SPK_MIX, 9'h001, 16'h0010);
    field(`OMV_OFF_SPK_MIX, 9'h002, 16'h0020);
    field(`OMV_OFF_SPK_MIX, 9'h020, 16'h0040);
    field(`OMV_OFF_MONO_MIX, 9'h001, 16'h0001);
    field(`OMV_OFF_MONO_MIX, 9'h002, 16'h0002);
    field(`OMV_OFF_MONO_MIX, 9'h004, 16'h0004);
    // immediate gain, extremes of the code, silence
    wr_reg(`OMV_OFF_SPK_VOL, 9'h03F);
    @(negedge clk);
    check({10'h000, gain}, 16'h003F);
    wr_reg(`OMV_OFF_SPK_VOL, 9'h000);
    @(negedge clk);
    check({10'h000, gain}, 16'h0000);
    wr_reg(`OMV_OFF_SPK_VOL, 9'h079);
    @(negedge clk);
    check({9'h000, silence, gain}, 16'h0079);
    check({15'h0000, neg_inv}, 16'h0001);
    wr_reg(`OMV_OFF_SPK_VOL, 9'h039);
    @(negedge clk);
    check({9'h000, silence, gain}, 16'h0039);
    // zero-cross update held until a crossing
    wr_reg(`OMV_OFF_SPK_VOL, 9'h0A0);
    repeat (5) @(negedge clk);
    check({10'h000, gain}, 16'h0039);
    rd_check(`OMV_OFF_ZC_STATUS, 9'h079);
    @(posedge clk);
    zc <= 1'b1;
    @(posedge clk);
    zc <= 1'b0;
    @(negedge clk);
    check({10'h000, gain}, 16'h0020);
    rd_check(`OMV_OFF_ZC_STATUS, 9'h020);
    // no timeout while the slow clock is off
    wr_reg(`OMV_OFF_SPK_VOL, 9'h0B0);
    wait_tick(1'b0, 40, n);
    check(n[15:0], 16'h0028);
    check({10'h000, gain}, 16'h0020);
    // timeout restarts on each pending write
    wr_reg(`OMV_OFF_ADD_CTRL, 9'h001);
    wr_reg(`OMV_OFF_SPK_VOL, 9'h0A8);
    wait_tick(1'b0, 8, n);
    check(n[15:0], 16'h0008);
    wr_reg(`OMV_OFF_SPK_VOL, 9'h0A9);
    wait_tick(1'b0, 40, n);
    check(16'(n >= ZC - 1 && n <= ZC + 1), 16'h0001);
    @(negedge clk);
    check({10'h000, gain}, 16'h0029);
    rd_check(`OMV_OFF_ZC_STATUS, 9'h029);
    // input stages waiting also run the timeout
    @(posedge clk);
    in_pend <= 1'b1;
    wait_tick(1'b0, 40, n);
    check(16'(n <= ZC + 2), 16'h0001);
    check({10'h000, gain}, 16'h0029);
    @(posedge clk);
    in_pend <= 1'b0;
    // slow tick period, then stopped when disabled
    wait_tick(1'b1, 40, n);
    wait_tick(1'b1, 40, m);
    check(m[15:0], 16'(ZC));
    wr_reg(`OMV_OFF_ADD_CTRL, 9'h000);
    wait_tick(1'b1, 40, n);
    check(n[15:0], 16'h0028);
    give_verdict();
  end

endmodule // tb
